// >>> common/cache_freeze_ctrl_cfg.svh
// Register offsets, field positions and reset values of the cache control block.
// Assumes a byte-addressed register port whose low 16 address bits select a register.
`ifndef CACHE_FREEZE_CTRL_CFG_SVH
`define CACHE_FREEZE_CTRL_CFG_SVH

`define CACHE_FREEZE_CTRL_OFF_CFG 16'h0000
`define CACHE_FREEZE_CTRL_OFF_WB_BASE 16'h4000
`define CACHE_FREEZE_CTRL_OFF_WB_CNT 16'h4004
`define CACHE_FREEZE_CTRL_OFF_WI_BASE 16'h4010
`define CACHE_FREEZE_CTRL_OFF_WI_CNT 16'h4014
`define CACHE_FREEZE_CTRL_OFF_IV_BASE 16'h4018
`define CACHE_FREEZE_CTRL_OFF_IV_CNT 16'h401c
`define CACHE_FREEZE_CTRL_OFF_GWB 16'h5000
`define CACHE_FREEZE_CTRL_OFF_GWI 16'h5004
`define CACHE_FREEZE_CTRL_OFF_GIV 16'h5008
`define CACHE_FREEZE_CTRL_OFF_STATUS 16'h5010

`define CACHE_FREEZE_CTRL_FREEZE_BIT 3
`define CACHE_FREEZE_CTRL_SIZE_MSB 2
`define CACHE_FREEZE_CTRL_TRIG_BIT 0
`define CACHE_FREEZE_CTRL_SIZE_MAX_CODE 3'h5
`define CACHE_FREEZE_CTRL_CNT_MAX 16'hffe0
`define CACHE_FREEZE_CTRL_RST_CNT 16'h0000
`define CACHE_FREEZE_CTRL_RST_BASE 32'h0000_0000
`define CACHE_FREEZE_CTRL_RST_SIZE 3'h0

`endif

// >>> common/cache_freeze_ctrl_op_if.sv
// Request and completion signals between register file and operation engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cache_freeze_ctrl_op_if;
    logic req;
    cache_freeze_ctrl_pkg::cache_freeze_ctrl_op_e kind;
    logic [31:0] addr;
    logic [15:0] words;
    logic accept;
    logic done;
    cache_freeze_ctrl_pkg::cache_freeze_ctrl_op_e done_kind;

    modport ctrl(output req, kind, addr, words, input accept, done, done_kind);
    modport engine(input req, kind, addr, words, output accept, done, done_kind);
endinterface

// >>> common/cache_freeze_ctrl_pkg.sv
// Types shared by the cache control block and its operation engine.
// Assumes nothing beyond a SystemVerilog compiler.
package cache_freeze_ctrl_pkg;
    localparam int CACHE_FREEZE_CTRL_NUM_OPS = 6;

    // Coherence operations, in service priority order.
    typedef enum logic [2:0] {
        CACHE_FREEZE_CTRL_OP_BLK_WB = 3'h0,
        CACHE_FREEZE_CTRL_OP_BLK_WI = 3'h1,
        CACHE_FREEZE_CTRL_OP_BLK_IV = 3'h2,
        CACHE_FREEZE_CTRL_OP_GLB_WB = 3'h3,
        CACHE_FREEZE_CTRL_OP_GLB_WI = 3'h4,
        CACHE_FREEZE_CTRL_OP_GLB_IV = 3'h5
    } cache_freeze_ctrl_op_e;

    // Effective cache size handed to the arrays.
    typedef enum logic [2:0] {
        CACHE_FREEZE_CTRL_SZ_OFF = 3'h0,
        CACHE_FREEZE_CTRL_SZ_32K = 3'h1,
        CACHE_FREEZE_CTRL_SZ_64K = 3'h2,
        CACHE_FREEZE_CTRL_SZ_128K = 3'h3,
        CACHE_FREEZE_CTRL_SZ_256K = 3'h4,
        CACHE_FREEZE_CTRL_SZ_MAX = 3'h5
    } cache_freeze_ctrl_size_e;

    // Engine states, Gray coded along idle, run, finish.
    typedef enum logic [1:0] {
        CACHE_FREEZE_CTRL_IDLE = 2'h0,
        CACHE_FREEZE_CTRL_RUN = 2'h1,
        CACHE_FREEZE_CTRL_FIN = 2'h3
    } cache_freeze_ctrl_state_e;
endpackage

// >>> hw/cache_freeze_ctrl_ctrl.sv
// Level-2 cache control: configuration and software coherence operations.
// Assumes a single-clock register port and cache arrays that take one operation at a time.
`timescale 1ns/1ps
`include "cache_freeze_ctrl_cfg.svh"
module cache_freeze_ctrl_ctrl #(
    parameter int ADDR_W = 16
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Register port.
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Cache configuration.
    output logic CACHE_FROZEN,
    output cache_freeze_ctrl_pkg::cache_freeze_ctrl_size_e CACHE_SIZE,
    // Coherence command port.
    output logic CACHE_REQ,
    output cache_freeze_ctrl_pkg::cache_freeze_ctrl_op_e CACHE_OP,
    output logic [31:0] CACHE_ADDR,
    output logic [15:0] CACHE_WORDS,
    input wire logic CACHE_DONE
);
    import cache_freeze_ctrl_pkg::*;

    // The offsets need 16 address bits.
    if (ADDR_W < 16) begin : g_chk
        $error("cache_freeze_ctrl_ctrl: ADDR_W must be at least 16.");
    end

    localparam int N = CACHE_FREEZE_CTRL_NUM_OPS;

    // Stored configuration.
    logic freeze;
    logic [2:0] size_sel;
    cache_freeze_ctrl_size_e next_size;

    // Block operation bases and counts.
    logic [31:0] wb_base;
    logic [31:0] wi_base;
    logic [31:0] iv_base;
    logic [15:0] wb_cnt;
    logic [15:0] wi_cnt;
    logic [15:0] iv_cnt;

    // Operation bookkeeping, one bit per operation.
    logic [N-1:0] pend;
    logic [N-1:0] active;
    logic [N-1:0] set_req;
    logic [N-1:0] pick_oh;
    logic [N-1:0] grant;
    logic [N-1:0] done_oh;
    logic [2:0] pick_idx;
    logic [15:0] pick_cnt;

    // Read path.
    logic [31:0] rmux;

    cache_freeze_ctrl_op_if op();

    // Address decode.
    wire sel_cfg = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_CFG);
    wire sel_wbb = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_WB_BASE);
    wire sel_wbc = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_WB_CNT);
    wire sel_wib = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_WI_BASE);
    wire sel_wic = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_WI_CNT);
    wire sel_ivb = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_IV_BASE);
    wire sel_ivc = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_IV_CNT);
    wire sel_gwb = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_GWB);
    wire sel_gwi = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_GWI);
    wire sel_giv = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_GIV);
    wire sel_sts = REG_ADDR == ADDR_W'(`CACHE_FREEZE_CTRL_OFF_STATUS);
    wire trig = REG_WDATA[`CACHE_FREEZE_CTRL_TRIG_BIT];

    // Start requests: a count write starts its block operation,
    // a one in a trigger bit starts its global operation.
    assign set_req[CACHE_FREEZE_CTRL_OP_BLK_WB] = REG_WR && sel_wbc;
    assign set_req[CACHE_FREEZE_CTRL_OP_BLK_WI] = REG_WR && sel_wic;
    assign set_req[CACHE_FREEZE_CTRL_OP_BLK_IV] = REG_WR && sel_ivc;
    assign set_req[CACHE_FREEZE_CTRL_OP_GLB_WB] = REG_WR && sel_gwb && trig;
    assign set_req[CACHE_FREEZE_CTRL_OP_GLB_WI] = REG_WR && sel_gwi && trig;
    assign set_req[CACHE_FREEZE_CTRL_OP_GLB_IV] = REG_WR && sel_giv && trig;

    // Size codes above the largest named size all mean maximum cache.
    assign next_size = (REG_WDATA[2:0] >= `CACHE_FREEZE_CTRL_SIZE_MAX_CODE) ? CACHE_FREEZE_CTRL_SZ_MAX
        : cache_freeze_ctrl_size_e'(REG_WDATA[2:0]);

    // Configuration register; CACHE_FROZEN follows the stored bit, CACHE_SIZE turns codes 5 to 7 into maximum.
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            freeze <= 1'b0;
            size_sel <= `CACHE_FREEZE_CTRL_RST_SIZE;
            CACHE_FROZEN <= 1'b0;
            CACHE_SIZE <= CACHE_FREEZE_CTRL_SZ_OFF;
        end else if (REG_WR && sel_cfg) begin
            freeze <= REG_WDATA[`CACHE_FREEZE_CTRL_FREEZE_BIT];
            size_sel <= REG_WDATA[`CACHE_FREEZE_CTRL_SIZE_MSB:0];
            CACHE_FROZEN <= REG_WDATA[`CACHE_FREEZE_CTRL_FREEZE_BIT];
            CACHE_SIZE <= next_size;
        end
    end

    // Base addresses are write-only; their reset value only avoids unknowns.
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            wb_base <= `CACHE_FREEZE_CTRL_RST_BASE;
            wi_base <= `CACHE_FREEZE_CTRL_RST_BASE;
            iv_base <= `CACHE_FREEZE_CTRL_RST_BASE;
        end else begin
            if (REG_WR && sel_wbb) begin
                wb_base <= REG_WDATA;
            end
            if (REG_WR && sel_wib) begin
                wi_base <= REG_WDATA;
            end
            if (REG_WR && sel_ivb) begin
                iv_base <= REG_WDATA;
            end
        end
    end

    // Word counts keep the full 16 bits written, so software reads back its value.
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            wb_cnt <= `CACHE_FREEZE_CTRL_RST_CNT;
            wi_cnt <= `CACHE_FREEZE_CTRL_RST_CNT;
            iv_cnt <= `CACHE_FREEZE_CTRL_RST_CNT;
        end else begin
            if (set_req[CACHE_FREEZE_CTRL_OP_BLK_WB]) begin
                wb_cnt <= REG_WDATA[15:0];
            end
            if (set_req[CACHE_FREEZE_CTRL_OP_BLK_WI]) begin
                wi_cnt <= REG_WDATA[15:0];
            end
            if (set_req[CACHE_FREEZE_CTRL_OP_BLK_IV]) begin
                iv_cnt <= REG_WDATA[15:0];
            end
        end
    end

    // Lowest-numbered pending operation goes first, only one at a time.
    function automatic logic [2:0] oh_to_idx(input logic [N-1:0] oh);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (oh[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    assign pick_oh = pend & (~pend + N'(1));
    assign pick_idx = oh_to_idx(pick_oh);
    assign grant = pick_oh & {N{op.accept}};
    assign done_oh = op.done ? (N'(1) << op.done_kind) : '0;

    // Counts past the limit behave as an empty block.
    assign pick_cnt = pick_oh[CACHE_FREEZE_CTRL_OP_BLK_WB] ? wb_cnt
        : pick_oh[CACHE_FREEZE_CTRL_OP_BLK_WI] ? wi_cnt
        : pick_oh[CACHE_FREEZE_CTRL_OP_BLK_IV] ? iv_cnt : 16'h0000;
    assign op.words = (pick_cnt > `CACHE_FREEZE_CTRL_CNT_MAX) ? 16'h0000 : pick_cnt;

    // Block operations take the latest base of their own pair.
    assign op.addr = pick_oh[CACHE_FREEZE_CTRL_OP_BLK_WB] ? wb_base
        : pick_oh[CACHE_FREEZE_CTRL_OP_BLK_WI] ? wi_base
        : pick_oh[CACHE_FREEZE_CTRL_OP_BLK_IV] ? iv_base : 32'h0000_0000;
    assign op.kind = cache_freeze_ctrl_op_e'(pick_idx);
    assign op.req = (|pend) && !(|active);

    // Pending and running flags per operation; a new start beats a grant,
    // so a request that lands in the grant cycle runs again afterwards.
    for (genvar g = 0; g < N; g++) begin : g_op
        always_ff @(posedge SYS_CLK) begin
            if (!RESET_N) begin
                pend[g] <= 1'b0;
                active[g] <= 1'b0;
            end else begin
                pend[g] <= set_req[g] || (pend[g] && !grant[g]);
                active[g] <= grant[g] || (active[g] && !done_oh[g]);
            end
        end
    end

    // The engine drives the arrays; a global invalidate is issued as its
    // own command kind, which the arrays carry out without writeback.
    cache_freeze_ctrl_engine u_engine (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .op(op.engine),
        .cache_off(size_sel == 3'h0),
        .cache_req(CACHE_REQ),
        .cache_op(CACHE_OP),
        .cache_addr(CACHE_ADDR),
        .cache_words(CACHE_WORDS),
        .cache_done(CACHE_DONE)
    );

    // Read multiplexer; bases read zero, reserved bits read zero.
    wire [N-1:0] busy = pend | active;
    assign rmux = sel_cfg ? {28'h0, freeze, size_sel}
        : sel_wbc ? {16'h0, wb_cnt}
        : sel_wic ? {16'h0, wi_cnt}
        : sel_ivc ? {16'h0, iv_cnt}
        : sel_gwb ? {31'h0, busy[CACHE_FREEZE_CTRL_OP_GLB_WB]}
        : sel_gwi ? {31'h0, busy[CACHE_FREEZE_CTRL_OP_GLB_WI]}
        : sel_giv ? {31'h0, busy[CACHE_FREEZE_CTRL_OP_GLB_IV]}
        : sel_sts ? {20'h0, active, pend} : 32'h0000_0000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else begin
            REG_RDATA <= REG_RD ? rmux : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_freeze;
        REG_WR && sel_cfg |=> CACHE_FROZEN == $past(REG_WDATA[3]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("Freeze output wrong.");

    property p_size_max;
        REG_WR && sel_cfg && REG_WDATA[2:0] >= 3'h5 |=> CACHE_SIZE == CACHE_FREEZE_CTRL_SZ_MAX;
    endproperty
    a_size_max: assert property (p_size_max) else $error("Size not maximum.");

    property p_wb_base;
        REG_WR && sel_wbb |=> wb_base == $past(REG_WDATA);
    endproperty
    a_wb_base: assert property (p_wb_base) else $error("Base not captured.");

    property p_wb_cnt_read;
        REG_RD && sel_wbc && !REG_WR |=> REG_RDATA == {16'h0, wb_cnt};
    endproperty
    a_wb_cnt_read: assert property (p_wb_cnt_read) else $error("Count read wrong.");

    property p_big_skip;
        op.accept && pick_cnt > 16'hffe0 && pick_oh[2:0] != 3'h0 |=> !CACHE_REQ ##1 !CACHE_REQ;
    endproperty
    a_big_skip: assert property (p_big_skip) else $error("Oversize count ran.");

    property p_wi_base;
        REG_WR && sel_wib |=> wi_base == $past(REG_WDATA);
    endproperty
    a_wi_base: assert property (p_wi_base) else $error("Base not captured.");

    property p_inv_read;
        REG_RD && sel_giv |=> REG_RDATA[31:1] == 31'h0;
    endproperty
    a_inv_read: assert property (p_inv_read) else $error("Reserved bits set.");

    property p_glb_busy;
        REG_WR && sel_gwb && REG_WDATA[0] |=> busy[CACHE_FREEZE_CTRL_OP_GLB_WB] [*2];
    endproperty
    a_glb_busy: assert property (p_glb_busy) else $error("Trigger not held.");

    property p_glb_clear;
        op.done && op.done_kind == CACHE_FREEZE_CTRL_OP_GLB_WI && !set_req[CACHE_FREEZE_CTRL_OP_GLB_WI]
            && !pend[CACHE_FREEZE_CTRL_OP_GLB_WI] |=> !busy[CACHE_FREEZE_CTRL_OP_GLB_WI];
    endproperty
    a_glb_clear: assert property (p_glb_clear) else $error("Trigger not cleared.");

    property p_start;
        REG_WR && sel_ivc && !(|pend) && !(|active) |=> op.accept && op.kind == CACHE_FREEZE_CTRL_OP_BLK_IV;
    endproperty
    a_start: assert property (p_start) else $error("Block op not started.");

    property p_size_off;
        REG_WR && sel_cfg && REG_WDATA[2:0] == 3'h0 |=> CACHE_SIZE == CACHE_FREEZE_CTRL_SZ_OFF;
    endproperty
    a_size_off: assert property (p_size_off) else $error("Size not off.");

    property p_size_named;
        REG_WR && sel_cfg && REG_WDATA[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4}
            |=> CACHE_SIZE == $past(REG_WDATA[2:0]);
    endproperty
    a_size_named: assert property (p_size_named) else $error("Named size wrong.");

    property p_iv_base;
        REG_WR && sel_ivb |=> iv_base == $past(REG_WDATA);
    endproperty
    a_iv_base: assert property (p_iv_base) else $error("Base not captured.");

    property p_wi_cnt_read;
        REG_RD && sel_wic |=> REG_RDATA == {16'h0, wi_cnt};
    endproperty
    a_wi_cnt_read: assert property (p_wi_cnt_read) else $error("Count read wrong.");

    property p_iv_cnt_read;
        REG_RD && sel_ivc |=> REG_RDATA == {16'h0, iv_cnt};
    endproperty
    a_iv_cnt_read: assert property (p_iv_cnt_read) else $error("Count read wrong.");

    property p_gwb_read;
        REG_RD && sel_gwb |=> REG_RDATA == {31'h0, $past(busy[CACHE_FREEZE_CTRL_OP_GLB_WB])};
    endproperty
    a_gwb_read: assert property (p_gwb_read) else $error("Trigger read wrong.");

    property p_gwi_read;
        REG_RD && sel_gwi |=> REG_RDATA == {31'h0, $past(busy[CACHE_FREEZE_CTRL_OP_GLB_WI])};
    endproperty
    a_gwi_read: assert property (p_gwi_read) else $error("Trigger read wrong.");

    property p_gwb_cmd;
        op.accept && op.kind == CACHE_FREEZE_CTRL_OP_GLB_WB && size_sel != 3'h0
            |=> CACHE_REQ && CACHE_OP == CACHE_FREEZE_CTRL_OP_GLB_WB;
    endproperty
    a_gwb_cmd: assert property (p_gwb_cmd) else $error("Writeback not issued.");

    property p_gwi_cmd;
        op.accept && op.kind == CACHE_FREEZE_CTRL_OP_GLB_WI && size_sel != 3'h0
            |=> CACHE_REQ && CACHE_OP == CACHE_FREEZE_CTRL_OP_GLB_WI;
    endproperty
    a_gwi_cmd: assert property (p_gwi_cmd) else $error("Flush not issued.");

    property p_giv_cmd;
        op.accept && op.kind == CACHE_FREEZE_CTRL_OP_GLB_IV && size_sel != 3'h0
            |=> CACHE_REQ && CACHE_OP == CACHE_FREEZE_CTRL_OP_GLB_IV;
    endproperty
    a_giv_cmd: assert property (p_giv_cmd) else $error("Invalidate not issued.");

    property p_req_hold;
        CACHE_REQ && !CACHE_DONE |=> CACHE_REQ && $stable(CACHE_OP) && $stable(CACHE_ADDR);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("Command not held.");

    property p_done_drop;
        CACHE_REQ && CACHE_DONE |=> !CACHE_REQ;
    endproperty
    a_done_drop: assert property (p_done_drop) else $error("Command not dropped.");
endmodule

// >>> hw/cache_freeze_ctrl_engine.sv
// Operation engine: runs one coherence operation at a time against the cache arrays.
// Assumes the arrays answer a held request with a one-cycle done on the same clock.
`timescale 1ns/1ps
module cache_freeze_ctrl_engine (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the register file.
    cache_freeze_ctrl_op_if.engine op,
    // Cache state.
    input wire logic cache_off,
    // Command port toward the cache arrays.
    output logic cache_req,
    output cache_freeze_ctrl_pkg::cache_freeze_ctrl_op_e cache_op,
    output logic [31:0] cache_addr,
    output logic [15:0] cache_words,
    input wire logic cache_done
);
    import cache_freeze_ctrl_pkg::*;

    cache_freeze_ctrl_state_e state;
    cache_freeze_ctrl_state_e next_state;
    cache_freeze_ctrl_op_e cur_kind;
    logic is_block;
    logic skip;

    // Empty blocks and a disabled cache leave nothing to touch, so no command goes out.
    assign is_block = op.kind inside {CACHE_FREEZE_CTRL_OP_BLK_WB, CACHE_FREEZE_CTRL_OP_BLK_WI, CACHE_FREEZE_CTRL_OP_BLK_IV};
    assign skip = cache_off || (is_block && op.words == 16'h0000);
    assign op.accept = (state == CACHE_FREEZE_CTRL_IDLE) && op.req;
    assign op.done = (state == CACHE_FREEZE_CTRL_FIN);
    assign op.done_kind = cur_kind;

    // Next state of the engine.
    always_comb begin
        next_state = state;
        case (state)
            CACHE_FREEZE_CTRL_IDLE: begin
                if (op.req) begin
                    next_state = skip ? CACHE_FREEZE_CTRL_FIN : CACHE_FREEZE_CTRL_RUN;
                end
            end
            CACHE_FREEZE_CTRL_RUN: begin
                if (cache_done) begin
                    next_state = CACHE_FREEZE_CTRL_FIN;
                end
            end
            CACHE_FREEZE_CTRL_FIN: next_state = CACHE_FREEZE_CTRL_IDLE;
            default: next_state = CACHE_FREEZE_CTRL_IDLE;
        endcase
    end

    // State and the held command; the request stays up until the arrays finish.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= CACHE_FREEZE_CTRL_IDLE;
            cur_kind <= CACHE_FREEZE_CTRL_OP_BLK_WB;
            cache_req <= 1'b0;
            cache_op <= CACHE_FREEZE_CTRL_OP_BLK_WB;
            cache_addr <= 32'h0000_0000;
            cache_words <= 16'h0000;
        end else begin
            state <= next_state;
            if (op.accept) begin
                cur_kind <= op.kind;
                cache_op <= op.kind;
                cache_addr <= op.addr;
                cache_words <= op.words;
            end
            cache_req <= (next_state == CACHE_FREEZE_CTRL_RUN);
        end
    end
endmodule

// >>> verif/cache_freeze_ctrl_ctrl_test.sv
// Self-checking bench for the level-2 cache control block, driving every port itself.
// Assumes the common headers and design files are compiled first; the bench plays the arrays.
`timescale 1ns/1ps
`include "cache_freeze_ctrl_cfg.svh"
module cache_freeze_ctrl_ctrl_test;
    import cache_freeze_ctrl_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic cache_frozen;
    cache_freeze_ctrl_size_e cache_size;
    logic cache_req;
    cache_freeze_ctrl_op_e cache_op;
    logic [31:0] cache_addr;
    logic [15:0] cache_words;
    logic cache_done = 1'b0;
    logic seen;
    int fails = 0;
    int compares = 0;

    // The clock runs at 40 MHz.
    always #12.5 sys_clk = ~sys_clk;

    cache_freeze_ctrl_ctrl #(.ADDR_W(16)) dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CACHE_FROZEN(cache_frozen), .CACHE_SIZE(cache_size), .CACHE_REQ(cache_req),
        .CACHE_OP(cache_op), .CACHE_ADDR(cache_addr), .CACHE_WORDS(cache_words),
        .CACHE_DONE(cache_done));

    // Prints the verdict once and ends the run.
    task automatic results();
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe; the strobe drops at the next edge.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask

    // Bounded wait for a command toward the arrays.
    task automatic wait_req(input int lim, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge sys_clk);
            #1;
            hit = (cache_req === 1'b1);
        end
    endtask

    // The arrays finish with a one-cycle done; the request must drop at the next edge.
    task automatic answer();
        @(posedge sys_clk);
        cache_done <= 1'b1;
        @(posedge sys_clk);
        cache_done <= 1'b0;
        #1;
        chk("req_after_done", {31'h0, cache_req}, 32'h0);
    endtask

    task automatic cmd_chk(input logic [2:0] op, input logic [31:0] a, input logic [15:0] w);
        wait_req(6, seen);
        chk("req", {31'h0, seen}, 32'h1);
        chk("op", {29'h0, cache_op}, {29'h0, op});
        chk("addr", cache_addr, a);
        chk("words", {16'h0, cache_words}, {16'h0, w});
    endtask

    task automatic t_reset();
        chk("out_idle", {cache_frozen, cache_size, cache_req}, 32'h0);
        rd_chk("cfg", `CACHE_FREEZE_CTRL_OFF_CFG, 32'h0);
        rd_chk("wb_cnt", `CACHE_FREEZE_CTRL_OFF_WB_CNT, 32'h0);
        rd_chk("wi_cnt", `CACHE_FREEZE_CTRL_OFF_WI_CNT, 32'h0);
        rd_chk("iv_cnt", `CACHE_FREEZE_CTRL_OFF_IV_CNT, 32'h0);
        rd_chk("gwb", `CACHE_FREEZE_CTRL_OFF_GWB, 32'h0);
        rd_chk("gwi", `CACHE_FREEZE_CTRL_OFF_GWI, 32'h0);
        rd_chk("giv", `CACHE_FREEZE_CTRL_OFF_GIV, 32'h0);
    endtask

    // Every size code, with the freeze bit alternating.
    task automatic t_config();
        for (int c = 0; c < 8; c++) begin
            wr(`CACHE_FREEZE_CTRL_OFF_CFG, {28'h0, c[0], c[2:0]});
            repeat (2) @(posedge sys_clk);
            #1;
            chk("frozen", {31'h0, cache_frozen}, {31'h0, c[0]});
            chk("size", {29'h0, cache_size}, (c >= 5) ? 32'h5 : c);
            rd_chk("cfg_rb", `CACHE_FREEZE_CTRL_OFF_CFG, {28'h0, c[0], c[2:0]});
        end
    endtask

    // Block operations, each with a decoy base written before the real one.
    task automatic t_block();
        logic [15:0] ob[3];
        logic [15:0] oc[3];
        logic [31:0] base;
        ob = '{`CACHE_FREEZE_CTRL_OFF_WB_BASE, `CACHE_FREEZE_CTRL_OFF_WI_BASE, `CACHE_FREEZE_CTRL_OFF_IV_BASE};
        oc = '{`CACHE_FREEZE_CTRL_OFF_WB_CNT, `CACHE_FREEZE_CTRL_OFF_WI_CNT, `CACHE_FREEZE_CTRL_OFF_IV_CNT};
        wr(`CACHE_FREEZE_CTRL_OFF_CFG, 32'h4);
        for (int i = 0; i < 3; i++) begin
            base = 32'h8000_1000 + 32'(i * 32'h40);
            wr(ob[i], 32'h1234_5678);
            wr(ob[i], base);
            wr(oc[i], 32'hbeef_0010 + 32'(i));
            cmd_chk(3'(i), base, 16'h0010 + 16'(i));
            repeat (3) @(posedge sys_clk);
            #1;
            chk("req_stands", {cache_req, cache_addr[30:0]}, {1'b1, base[30:0]});
            answer();
            rd_chk("cnt_rb", oc[i], 32'h0010 + 32'(i));
            rd_chk("base_rb", ob[i], 32'h0);
        end
    endtask

    // Counts above the limit touch nothing; the limit itself still runs.
    task automatic t_range();
        wr(`CACHE_FREEZE_CTRL_OFF_IV_CNT, 32'h0000_ffe1);
        wait_req(8, seen);
        chk("ffe1_noreq", {31'h0, seen}, 32'h0);
        wr(`CACHE_FREEZE_CTRL_OFF_WI_CNT, 32'h0000_ffff);
        wait_req(8, seen);
        chk("ffff_noreq", {31'h0, seen}, 32'h0);
        wr(`CACHE_FREEZE_CTRL_OFF_WB_BASE, 32'h0000_2000);
        wr(`CACHE_FREEZE_CTRL_OFF_WB_CNT, 32'h0000_ffe0);
        cmd_chk(3'h0, 32'h0000_2000, 16'hffe0);
        answer();
    endtask

    // Global triggers read 1 while running, refuse a cancel, then clear.
    task automatic t_global();
        logic [15:0] og[3];
        og = '{`CACHE_FREEZE_CTRL_OFF_GWB, `CACHE_FREEZE_CTRL_OFF_GWI, `CACHE_FREEZE_CTRL_OFF_GIV};
        for (int j = 0; j < 3; j++) begin
            wr(og[j], 32'hffff_ffff);
            cmd_chk(3'(j + 3), 32'h0, 16'h0);
            rd_chk("trig_busy", og[j], 32'h1);
            wr(og[j], 32'h0);
            rd_chk("trig_kept", og[j], 32'h1);
            answer();
            repeat (3) @(posedge sys_clk);
            rd_chk("trig_clear", og[j], 32'h0);
        end
    endtask

    // Ops queued behind a running one are served lowest number first.
    task automatic t_order();
        wr(`CACHE_FREEZE_CTRL_OFF_GWB, 32'h1);
        cmd_chk(3'h3, 32'h0, 16'h0);
        wr(`CACHE_FREEZE_CTRL_OFF_IV_BASE, 32'h0000_3000);
        wr(`CACHE_FREEZE_CTRL_OFF_IV_CNT, 32'h5);
        wr(`CACHE_FREEZE_CTRL_OFF_WB_BASE, 32'h0000_4000);
        wr(`CACHE_FREEZE_CTRL_OFF_WB_CNT, 32'h7);
        // Global writeback running, block invalidate and block writeback waiting.
        rd_chk("status", `CACHE_FREEZE_CTRL_OFF_STATUS, 32'h0000_0205);
        answer();
        cmd_chk(3'h0, 32'h0000_4000, 16'h7);
        answer();
        cmd_chk(3'h2, 32'h0000_3000, 16'h5);
        answer();
    endtask

    // A disabled cache takes no command, yet triggers still complete.
    task automatic t_off();
        wr(`CACHE_FREEZE_CTRL_OFF_CFG, 32'h0);
        wr(`CACHE_FREEZE_CTRL_OFF_WB_CNT, 32'h8);
        wait_req(8, seen);
        chk("off_noreq", {31'h0, seen}, 32'h0);
        wr(`CACHE_FREEZE_CTRL_OFF_GIV, 32'h1);
        wait_req(8, seen);
        chk("off_gnoreq", {31'h0, seen}, 32'h0);
        rd_chk("off_giv", `CACHE_FREEZE_CTRL_OFF_GIV, 32'h0);
    endtask

    // An unmapped place reads zero, and read data last one cycle only.
    task automatic t_unmapped();
        wr(16'h4008, 32'hffff_ffff);
        rd_chk("unmapped", 16'h4008, 32'h0);
        rd_chk("wb_cnt_kept", `CACHE_FREEZE_CTRL_OFF_WB_CNT, 32'h8);
        @(posedge sys_clk);
        #1;
        chk("rdata_drop", reg_rdata, 32'h0);
    endtask

    // Main sequence; reset is released after 20 cycles.
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_config();
        t_block();
        t_range();
        t_global();
        t_order();
        t_off();
        t_unmapped();
        results();
    end

    // The tests need well under a thousand cycles; five thousand means a hang.
    initial begin
        #125000;
        fails++;
        results();
    end
endmodule
